/* File: rtl/link_host_pkg.sv */
// Constants, codes and carrier types of the link host interface
package link_host_pkg;

   // ********************************************************
   // Register map
   // ********************************************************
   localparam logic [7:0] ADDR_CTRL_ONE = 8'h3c;
   localparam logic [7:0] ADDR_CTRL_TWO = 8'h3d;
   localparam logic [7:0] ADDR_VECTOR   = 8'h3e;
   localparam logic [7:0] ADDR_DATA     = 8'h3f;

   // ********************************************************
   // Fields and reset values
   // ********************************************************
   localparam int         IE_BIT       = 0;
   localparam int         WCM_BIT      = 1;
   localparam int         MODE_LSB     = 6;
   localparam int         TX_END_OF_DATA_BIT_BIT     = 0;
   localparam int         VEC_LSB      = 2;
   localparam logic       IE_RST       = 1'b0;
   localparam logic       WCM_RST      = 1'b0;
   localparam logic [7:0] BYTE_RST     = 8'h00;
   localparam logic [7:0] ONES_BYTE    = 8'hff;
   localparam int         EXTRA_ONES   = 2;
   localparam logic       BUS_ACTIVE   = 1'b1;

   // ********************************************************
   // Interrupt source codes, priority rises with the code
   // ********************************************************
   localparam int NUM_SRC = 8;
   typedef enum logic [3:0] {
      SRC_NONE     = 4'h0,
      SRC_EOF      = 4'h1,
      SRC_RX_IFR   = 4'h2,
      SRC_RX_FULL  = 4'h3,
      SRC_TX_EMPTY = 4'h4,
      SRC_ARB_LOSS = 4'h5,
      SRC_CRC      = 4'h6,
      SRC_SYMBOL   = 4'h7,
      SRC_WAKE     = 4'h8
   } src_code_t;

   typedef enum logic [1:0] {
      MODE_RUN     = 2'b00,
      MODE_WAIT    = 2'b01,
      MODE_STOP    = 2'b10,
      MODE_RESTART = 2'b11
   } mode_t;

   // Events from the symbol decoder, same clock
   typedef struct packed {
      logic       byte_valid;
      logic       ifr;
      logic       eof;
      logic       arb_lost;
      logic       crc_err;
      logic       bad_symbol;
      logic [7:0] data;
   } rx_evt_t;

endpackage

/* File: rtl/tx_shifter.sv */
// Transmit shift register, MSB first, one bit per bit tick
`timescale 1ns/10ps
module tx_shifter #(
   parameter int W = 8
) (
   input  wire logic         clk_i,
   input  wire logic         resetn_i,
   input  wire logic         bit_tick_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] data_i,
   input  wire logic [3:0]   len_i,
   output logic              busy_o,
   output logic              bit_o,
   output logic              first_o,
   output logic              done_o
);

   if (W < 2 || W > 15) begin : g_bad_width
      $error("tx_shifter: W out of range");
   end

   logic [W-1:0] sr_r;
   logic [3:0]   left_r;
   logic [3:0]   len_r;
   logic         active_r;

   wire tick_on = bit_tick_i & active_r;
   wire emit    = tick_on & (left_r != 4'h0);
   wire finish  = tick_on & (left_r == 4'h0);

   assign busy_o = active_r;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sr_r     <= '0;
         left_r   <= 4'h0;
         len_r    <= 4'h0;
         active_r <= 1'b0;
         bit_o    <= 1'b0;
         first_o  <= 1'b0;
         done_o   <= 1'b0;
      end else begin
         first_o <= emit & (left_r == len_r - 4'h1);
         done_o  <= finish;
         if (load_i && !active_r) begin
            sr_r     <= data_i;
            left_r   <= len_i;
            len_r    <= len_i;
            active_r <= 1'b1;
         end else if (emit) begin
            bit_o  <= sr_r[W-1];
            sr_r   <= {sr_r[W-2:0], 1'b0};
            left_r <= left_r - 4'h1;
         end else if (finish) begin
            active_r <= 1'b0;
         end
      end
   end

endmodule // tx_shifter

/* File: rtl/link_host_if.sv */
// Host side of the byte-level link controller: vector, data buffers, low power
`timescale 1ns/10ps
module link_host_if #(
   parameter int STAB_CYCLES = 64
) (
   input  wire logic                   clk_i,
   input  wire logic                   resetn_i,
   input  wire logic [7:0]             addr_i,
   input  wire logic [7:0]             wdata_i,
   input  wire logic                   wr_i,
   input  wire logic                   rd_i,
   output logic [7:0]                  rdata_o,
   input  wire logic                   cpu_wait_i,
   input  wire logic                   cpu_stop_i,
   input  wire link_host_pkg::rx_evt_t rx_evt_i,
   input  wire logic                   bit_tick_i,
   input  wire logic                   bus_rx_i,
   output logic                        bus_tx_o,
   output logic                        bus_tx_oe_n_o,
   output logic                        irq_o,
   output logic                        wake_nmi_o,
   output logic                        clk_run_o
);

   if (STAB_CYCLES < 1 || STAB_CYCLES > 65535) begin : g_bad_stab
      $error("link_host_if: STAB_CYCLES out of range");
   end

   // ********************************************************
   // Decode helpers
   // ********************************************************
   function automatic link_host_pkg::src_code_t top_code(input logic [8:1] p);
      top_code = link_host_pkg::SRC_NONE;
      for (int i = 1; i <= link_host_pkg::NUM_SRC; i++) begin
         if (p[i]) begin
            top_code = link_host_pkg::src_code_t'(4'(i));
         end
      end
   endfunction

   function automatic logic [8:1] src_bit(input link_host_pkg::src_code_t c);
      src_bit = '0;
      for (int i = 1; i <= link_host_pkg::NUM_SRC; i++) begin
         if (4'(i) == c) begin
            src_bit[i] = 1'b1;
         end
      end
   endfunction

   // ********************************************************
   // State
   // ********************************************************
   logic [8:1]               pend_r;
   logic [8:1]               pend_nxt;
   logic                     arm_rx_r;
   logic                     arm_tx_r;
   logic                     ie_r;
   logic                     wcm_r;
   logic                     tx_end_of_data_bit_r;
   logic [7:0]               tx_shadow_r;
   logic                     shadow_full_r;
   logic                     tx_on_r;
   logic                     ones_phase_r;
   logic [7:0]               rx_shadow_r;
   link_host_pkg::mode_t     mode_r;
   link_host_pkg::mode_t     mode_nxt;
   logic [15:0]              stab_r;
   logic                     frame_idle_r;
   logic                     clean_stop_r;
   logic                     discard_r;
   logic                     pin_s1_r;
   logic                     pin_s2_r;
   logic                     pin_s3_r;
   logic                     sh_busy;
   logic                     sh_bit;
   logic                     sh_first;
   logic                     sh_done;

   // ********************************************************
   // Bus decode
   // ********************************************************
   wire rd_vec  = rd_i & (addr_i == link_host_pkg::ADDR_VECTOR);
   wire rd_data = rd_i & (addr_i == link_host_pkg::ADDR_DATA);
   wire wr_data = wr_i & (addr_i == link_host_pkg::ADDR_DATA);
   wire wr_one  = wr_i & (addr_i == link_host_pkg::ADDR_CTRL_ONE);
   wire wr_two  = wr_i & (addr_i == link_host_pkg::ADDR_CTRL_TWO);
   wire tx_end_of_data_bit_set = wr_two & wdata_i[link_host_pkg::TX_END_OF_DATA_BIT_BIT];

   link_host_pkg::src_code_t cur_code;
   assign cur_code = top_code(pend_r);

   wire cur_rx   = (cur_code == link_host_pkg::SRC_RX_FULL) |
                   (cur_code == link_host_pkg::SRC_RX_IFR);
   wire cur_tx   = (cur_code == link_host_pkg::SRC_TX_EMPTY);
   wire [7:0] vec_val = {2'b00, cur_code, 2'b00};

   // ********************************************************
   // Mode control
   // ********************************************************
   wire running   = (mode_r == link_host_pkg::MODE_RUN);
   wire listening = running | (mode_r == link_host_pkg::MODE_WAIT);
   wire bus_edge  = (pin_s2_r == link_host_pkg::BUS_ACTIVE) &
                    (pin_s3_r != link_host_pkg::BUS_ACTIVE);
   wire good_eof  = rx_evt_i.eof & ~rx_evt_i.crc_err;
   wire go_stop   = cpu_stop_i | (cpu_wait_i & wcm_r);
   wire go_wait   = cpu_wait_i & ~wcm_r & ~cpu_stop_i;
   wire wait_wake = (mode_r == link_host_pkg::MODE_WAIT) & good_eof;
   wire stop_wake = (mode_r == link_host_pkg::MODE_STOP) & bus_edge;
   wire stab_done = (stab_r == 16'h0001);

   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         link_host_pkg::MODE_RUN: begin
            if (go_stop) begin
               mode_nxt = link_host_pkg::MODE_STOP;
            end else if (go_wait) begin
               mode_nxt = link_host_pkg::MODE_WAIT;
            end
         end
         link_host_pkg::MODE_WAIT: begin
            if (wait_wake) begin
               mode_nxt = link_host_pkg::MODE_RUN;
            end
         end
         link_host_pkg::MODE_STOP: begin
            if (bus_edge) begin
               mode_nxt = link_host_pkg::MODE_RESTART;
            end
         end
         link_host_pkg::MODE_RESTART: begin
            if (stab_done) begin
               mode_nxt = link_host_pkg::MODE_RUN;
            end
         end
         default: mode_nxt = link_host_pkg::MODE_RUN;
      endcase
   end

   // ********************************************************
   // Receive path
   // ********************************************************
   // Events are lost while the clock is stopped or settling
   wire rx_take = listening & rx_evt_i.byte_valid & ~discard_r;
   wire ev_on   = listening & ~discard_r;

   // ********************************************************
   // Transmit path
   // ********************************************************
   wire sh_load_byte = running & ~sh_busy & ~ones_phase_r & shadow_full_r &
                       (~tx_on_r | ~sh_done);
   wire underrun     = sh_done & tx_on_r & ~ones_phase_r & ~shadow_full_r & ~tx_end_of_data_bit_r;
   wire frame_end    = sh_done & tx_on_r & ~ones_phase_r & ~shadow_full_r & tx_end_of_data_bit_r;
   wire abort_done   = sh_done & ones_phase_r;
   wire sh_load      = sh_load_byte | underrun;
   wire [7:0] sh_data = underrun ? link_host_pkg::ONES_BYTE : tx_shadow_r;
   wire [3:0] sh_len  = underrun ? 4'(link_host_pkg::EXTRA_ONES) : 4'd8;

   tx_shifter #(
      .W (8)
   ) u_tx_shifter (
      .clk_i      (clk_i),
      .resetn_i   (resetn_i),
      .bit_tick_i (bit_tick_i),
      .load_i     (sh_load),
      .data_i     (sh_data),
      .len_i      (sh_len),
      .busy_o     (sh_busy),
      .bit_o      (sh_bit),
      .first_o    (sh_first),
      .done_o     (sh_done)
   );

   // ********************************************************
   // Pending sources: set wins over clear
   // ********************************************************
   wire [8:1] set_vec =
      ({8{ev_on & good_eof}}                        & src_bit(link_host_pkg::SRC_EOF))      |
      ({8{rx_take & rx_evt_i.ifr}}                  & src_bit(link_host_pkg::SRC_RX_IFR))   |
      ({8{rx_take & ~rx_evt_i.ifr}}                 & src_bit(link_host_pkg::SRC_RX_FULL))  |
      ({8{sh_first & ~ones_phase_r}}                & src_bit(link_host_pkg::SRC_TX_EMPTY)) |
      ({8{ev_on & rx_evt_i.arb_lost}}               & src_bit(link_host_pkg::SRC_ARB_LOSS)) |
      ({8{ev_on & rx_evt_i.crc_err}}                & src_bit(link_host_pkg::SRC_CRC))      |
      ({8{(ev_on & rx_evt_i.bad_symbol) | abort_done}} & src_bit(link_host_pkg::SRC_SYMBOL)) |
      ({8{wait_wake | stop_wake}}                   & src_bit(link_host_pkg::SRC_WAKE));

   wire [8:1] clr_vec =
      ({8{rd_vec & ~cur_rx & ~cur_tx}} & src_bit(cur_code))                    |
      ({8{rd_data & arm_rx_r}} & (src_bit(link_host_pkg::SRC_RX_FULL) |
                                  src_bit(link_host_pkg::SRC_RX_IFR)))         |
      ({8{(wr_data & arm_tx_r) | tx_end_of_data_bit_set}} & src_bit(link_host_pkg::SRC_TX_EMPTY));

   assign pend_nxt = (pend_r & ~clr_vec) | set_vec;

   // ********************************************************
   // Registers
   // ********************************************************
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pend_r   <= '0;
         arm_rx_r <= 1'b0;
         arm_tx_r <= 1'b0;
      end else begin
         pend_r <= pend_nxt;
         if (rd_data) begin
            arm_rx_r <= 1'b0;
         end else if (rd_vec && cur_rx) begin
            arm_rx_r <= 1'b1;
         end
         if (wr_data || tx_end_of_data_bit_set) begin
            arm_tx_r <= 1'b0;
         end else if (rd_vec && cur_tx) begin
            arm_tx_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ie_r   <= link_host_pkg::IE_RST;
         wcm_r  <= link_host_pkg::WCM_RST;
      end else if (wr_one) begin
         ie_r  <= wdata_i[link_host_pkg::IE_BIT];
         wcm_r <= wdata_i[link_host_pkg::WCM_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_shadow_r   <= link_host_pkg::BYTE_RST;
         shadow_full_r <= 1'b0;
         tx_on_r       <= 1'b0;
         ones_phase_r  <= 1'b0;
         tx_end_of_data_bit_r        <= 1'b0;
      end else begin
         if (wr_data) begin
            tx_shadow_r   <= wdata_i;
            shadow_full_r <= 1'b1;
         end else if (sh_load_byte) begin
            shadow_full_r <= 1'b0;
         end
         if (sh_load_byte) begin
            tx_on_r <= 1'b1;
         end else if (frame_end || abort_done) begin
            tx_on_r <= 1'b0;
         end
         if (underrun) begin
            ones_phase_r <= 1'b1;
         end else if (abort_done) begin
            ones_phase_r <= 1'b0;
         end
         if (tx_end_of_data_bit_set) begin
            tx_end_of_data_bit_r <= 1'b1;
         end else if (frame_end) begin
            tx_end_of_data_bit_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_shadow_r <= link_host_pkg::BYTE_RST;
      end else if (rx_take) begin
         rx_shadow_r <= rx_evt_i.data;
      end
   end

   // Pin crosses into the clock domain before the edge detector
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_s1_r <= ~link_host_pkg::BUS_ACTIVE;
         pin_s2_r <= ~link_host_pkg::BUS_ACTIVE;
         pin_s3_r <= ~link_host_pkg::BUS_ACTIVE;
      end else begin
         pin_s1_r <= bus_rx_i;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_r       <= link_host_pkg::MODE_RUN;
         stab_r       <= 16'h0000;
         frame_idle_r <= 1'b1;
         clean_stop_r <= 1'b0;
         discard_r    <= 1'b0;
         wake_nmi_o   <= 1'b0;
      end else begin
         mode_r     <= mode_nxt;
         wake_nmi_o <= stop_wake;
         if (stop_wake) begin
            stab_r <= 16'(STAB_CYCLES);
         end else if (stab_r != 16'h0000) begin
            stab_r <= stab_r - 16'h0001;
         end
         if (rx_evt_i.eof) begin
            frame_idle_r <= 1'b1;
         end else if (rx_evt_i.byte_valid) begin
            frame_idle_r <= 1'b0;
         end
         if (running && go_stop) begin
            clean_stop_r <= cpu_wait_i & ~cpu_stop_i & frame_idle_r;
         end
         // Only a stop from a wait at frame idle keeps the waking byte
         if (stop_wake) begin
            discard_r <= ~clean_stop_r;
         end else if (listening && rx_evt_i.eof) begin
            discard_r <= 1'b0;
         end
      end
   end

   // ********************************************************
   // Outputs
   // ********************************************************
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o       <= 8'h00;
         bus_tx_o      <= 1'b0;
         bus_tx_oe_n_o <= 1'b1;
      end else begin
         bus_tx_o      <= sh_bit;
         bus_tx_oe_n_o <= ~(sh_busy & running);
         if (rd_vec) begin
            rdata_o <= vec_val;
         end else if (rd_data) begin
            rdata_o <= rx_shadow_r;
         end else if (rd_i && addr_i == link_host_pkg::ADDR_CTRL_ONE) begin
            rdata_o <= {mode_r, 4'h0, wcm_r, ie_r};
         end else if (rd_i && addr_i == link_host_pkg::ADDR_CTRL_TWO) begin
            rdata_o <= {7'h00, tx_end_of_data_bit_r};
         end else begin
            rdata_o <= 8'h00;
         end
      end
   end

   assign irq_o     = ie_r & (pend_r != '0);
   assign clk_run_o = (mode_r != link_host_pkg::MODE_STOP);

endmodule // link_host_if

/* File: tb/link_host_if_asserts.sv */
// Port-level checks of the link host interface
`timescale 1ns/10ps
module link_host_if_asserts #(
   parameter int STAB_CYCLES = 64
) (
   input wire logic                   clk_i,
   input wire logic                   resetn_i,
   input wire logic [7:0]             addr_i,
   input wire logic [7:0]             wdata_i,
   input wire logic                   wr_i,
   input wire logic                   rd_i,
   input wire logic [7:0]             rdata_o,
   input wire logic                   cpu_wait_i,
   input wire logic                   cpu_stop_i,
   input wire link_host_pkg::rx_evt_t rx_evt_i,
   input wire logic                   bit_tick_i,
   input wire logic                   bus_rx_i,
   input wire logic                   bus_tx_o,
   input wire logic                   bus_tx_oe_n_o,
   input wire logic                   irq_o,
   input wire logic                   wake_nmi_o,
   input wire logic                   clk_run_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   // ************************************************
   // Receive then read, in steps
   // ************************************************
   sequence s_rx_byte;
      rx_evt_i.byte_valid && !rx_evt_i.ifr && clk_run_o;
   endsequence
   sequence s_data_rd;
      rd_i && addr_i == link_host_pkg::ADDR_DATA;
   endsequence

   a_rx_byte_read: assert property (
      s_rx_byte ##2 s_data_rd |=> rdata_o == $past(rx_evt_i.data, 3))
      else $error("data read misses the byte just received");
   a_rdata_idle: assert property (
      !rd_i |=> rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   a_vec_format: assert property (
      rd_i && addr_i == link_host_pkg::ADDR_VECTOR |=>
      rdata_o[7:6] == 2'b00 && rdata_o[1:0] == 2'b00 && rdata_o[5:2] <= 4'h8)
      else $error("vector read has a bad format");
   a_stop_entry: assert property (
      cpu_stop_i |-> ##[1:2] !clk_run_o)
      else $error("stop request did not stop the clocks");
   a_wait_no_drive: assert property (
      cpu_wait_i |-> ##2 bus_tx_oe_n_o)
      else $error("bus still driven after wait");
   a_stop_no_drive: assert property (
      !clk_run_o && !$past(clk_run_o) |-> bus_tx_oe_n_o)
      else $error("bus driven in stop mode");
   a_bus_wake: assert property (
      $rose(bus_rx_i) && !clk_run_o |-> ##[1:5] wake_nmi_o)
      else $error("bus activity did not wake from stop");
   a_wake_pulse: assert property (
      wake_nmi_o |=> !wake_nmi_o)
      else $error("wake request longer than one cycle");
endmodule // link_host_if_asserts

bind link_host_if link_host_if_asserts #(.STAB_CYCLES(STAB_CYCLES)) u_asserts (
   .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cpu_wait_i(cpu_wait_i),
   .cpu_stop_i(cpu_stop_i), .rx_evt_i(rx_evt_i), .bit_tick_i(bit_tick_i),
   .bus_rx_i(bus_rx_i), .bus_tx_o(bus_tx_o), .bus_tx_oe_n_o(bus_tx_oe_n_o),
   .irq_o(irq_o), .wake_nmi_o(wake_nmi_o), .clk_run_o(clk_run_o)
);

/* File: tb/bus_node_model.sv */
// Far-side bus node: bit ticks, decoded receive events and raw bus level
`timescale 1ns/10ps
module bus_node_model #(
   parameter int TICK_DIV = 12
) (
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   output link_host_pkg::rx_evt_t rx_evt_o,
   output logic                   bit_tick_o,
   output logic                   bus_rx_o
);
   logic [7:0] div_r;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         div_r <= 8'h00;
      end else if (div_r == 8'(TICK_DIV - 1)) begin
         div_r <= 8'h00;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end
   assign bit_tick_o = resetn_i && (div_r == 8'h00);

   initial begin
      rx_evt_o = '0;
      bus_rx_o = ~link_host_pkg::BUS_ACTIVE;
   end

   // Stale data is inverted so a late sample never matches by luck
   task automatic event_pulse(input link_host_pkg::rx_evt_t e, input int gap);
      @(posedge clk_i);
      rx_evt_o <= e;
      @(posedge clk_i);
      rx_evt_o <= '{data: ~e.data, default: 1'b0};
      repeat (gap) @(posedge clk_i);
   endtask

   // Bus goes active for a symbol before the decoder reports the byte
   task automatic frame_byte(input logic [7:0] d, input logic ifr, input int gap);
      @(posedge clk_i);
      bus_rx_o <= link_host_pkg::BUS_ACTIVE;
      repeat (20) @(posedge clk_i);
      bus_rx_o <= ~link_host_pkg::BUS_ACTIVE;
      event_pulse('{byte_valid: 1'b1, ifr: ifr, data: d, default: 1'b0}, gap);
   endtask
endmodule // bus_node_model

/* File: tb/link_host_if_tb.sv */
// Self-checking bench of the link host interface
`timescale 1ns/10ps
module link_host_if_tb;
   localparam logic [7:0] VEC = link_host_pkg::ADDR_VECTOR;
   localparam logic [7:0] DAT = link_host_pkg::ADDR_DATA;
   localparam logic [7:0] CT1 = link_host_pkg::ADDR_CTRL_ONE;
   logic                   clk, resetn, wr, rd, cpu_wait, cpu_stop, tick, bus_rx;
   logic                   bus_tx, oe_n, irq, wake, clk_run;
   logic [7:0]             addr, wdata, rdata, v, b, b2;
   logic [9:0]             sh;
   link_host_pkg::rx_evt_t evt, ev_req;
   int                     fails = 0;
   int                     n_compared = 0;
   int                     cyc = 0;

   link_host_if #(.STAB_CYCLES(4)) uut (
      .clk_i(clk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .cpu_wait_i(cpu_wait), .cpu_stop_i(cpu_stop),
      .rx_evt_i(evt), .bit_tick_i(tick), .bus_rx_i(bus_rx), .bus_tx_o(bus_tx),
      .bus_tx_oe_n_o(oe_n), .irq_o(irq), .wake_nmi_o(wake), .clk_run_o(clk_run));
   bus_node_model #(.TICK_DIV(12)) node (
      .clk_i(clk), .resetn_i(resetn), .rx_evt_o(evt), .bit_tick_o(tick),
      .bus_rx_o(bus_rx));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ************************************************
   // Bus cycles, checks and the verdict
   // ************************************************
   task automatic print_verdict();
      if (fails == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [7:0] vec_of(input int code);
      return 8'(code * 4);
   endfunction
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
      chk(v, exp);
   endtask
   task automatic drain();
      repeat (4) begin
         @(posedge clk);
         addr <= VEC;
         rd <= 1'b1;
         @(posedge clk);
         addr <= DAT;
         @(posedge clk);
         rd <= 1'b0;
      end
   endtask
   task automatic cpu_op(input logic stop_op);
      @(posedge clk);
      cpu_stop <= stop_op;
      cpu_wait <= !stop_op;
      @(posedge clk);
      {cpu_stop, cpu_wait} <= 2'b00;
      @(negedge clk);
   endtask
   // Waits on the model's free-running tick, then samples bus_tx three clocks later, one bit per tick
   task automatic get_bits(input int n);
      repeat (n) begin
         do @(negedge clk); while (tick !== 1'b1);
         repeat (3) @(posedge clk);
         @(negedge clk);
         sh = {sh[8:0], bus_tx};
      end
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails++;
         $display("[ERR] %0t run did not finish", $time);
         print_verdict();
      end
   end

   // ************************************************
   // Scenarios
   // ************************************************
   initial begin
      {resetn, wr, rd, cpu_wait, cpu_stop, addr, wdata} = '0;
      void'($urandom(88870));
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      rd_chk(VEC, 8'h00);
      wr_reg(8'h00, 8'hff);
      rd_chk(8'h00, 8'h00);
      wr_reg(CT1, 8'h01);
      b = 8'($urandom);
      node.frame_byte(b, 1'b0, 0);
      node.event_pulse('{eof: 1'b1, default: 1'b0}, 0);
      node.event_pulse('{crc_err: 1'b1, default: 1'b0}, 0);
      chk({7'h00, irq}, 8'h01);
      rd_chk(VEC, vec_of(6));
      rd_chk(VEC, vec_of(3));
      rd_chk(VEC, vec_of(3));
      rd_chk(DAT, b);
      wr_reg(VEC, 8'hff);
      rd_chk(VEC, vec_of(1));
      rd_chk(VEC, 8'h00);
      for (int k = 0; k < 3; k++) begin
         ev_req = '0;
         ev_req[10 - k] = 1'b1;
         node.event_pulse(ev_req, k);
         rd_chk(VEC, vec_of(5 + k));
         rd_chk(VEC, 8'h00);
      end
      for (int i = 0; i < 6; i++) begin
         b = 8'($urandom);
         node.frame_byte(b, i[0], i[0] ? $urandom_range(30) : 0);
         rd_chk(DAT, b);
         rd_chk(VEC, vec_of(i[0] ? 2 : 3));
         rd_chk(DAT, b);
         rd_chk(VEC, 8'h00);
      end
      b2 = 8'($urandom);
      node.frame_byte(b, 1'b0, 0);
      node.frame_byte(b2, 1'b0, 0);
      rd_chk(VEC, vec_of(3));
      rd_chk(DAT, b2);
      cpu_op(1'b0);
      rd_chk(CT1, 8'h41);
      chk({6'h00, oe_n, clk_run}, 8'h03);
      node.frame_byte(b, 1'b0, 3);
      node.event_pulse('{eof: 1'b1, default: 1'b0}, 2);
      chk({7'h00, irq}, 8'h01);
      rd_chk(CT1, 8'h01);
      rd_chk(VEC, vec_of(8));
      drain();
      wr_reg(CT1, 8'h03);
      cpu_op(1'b0);
      chk({7'h00, clk_run}, 8'h00);
      node.frame_byte(b2, 1'b0, 0);
      rd_chk(VEC, vec_of(8));
      rd_chk(VEC, vec_of(3));
      rd_chk(DAT, b2);
      wr_reg(CT1, 8'h01);
      node.frame_byte(b, 1'b0, 0);
      drain();
      cpu_op(1'b1);
      chk({7'h00, clk_run}, 8'h00);
      node.frame_byte(~b, 1'b0, 0);
      chk({7'h00, irq}, 8'h01);
      rd_chk(VEC, vec_of(8));
      rd_chk(VEC, 8'h00);
      rd_chk(DAT, b);
      node.event_pulse('{eof: 1'b1, default: 1'b0}, 0);
      drain();
      get_bits(1);
      wr_reg(DAT, b);
      get_bits(2);
      rd_chk(VEC, vec_of(4));
      wr_reg(DAT, b2);
      get_bits(6);
      chk(sh[7:0], b);
      get_bits(9);
      chk(sh[7:0], b2);
      get_bits(2);
      chk({6'h00, oe_n, sh[0]}, 8'h01);
      get_bits(3);
      chk({7'h00, oe_n}, 8'h01);
      rd_chk(VEC, vec_of(7));
      rd_chk(VEC, vec_of(4));
      wr_reg(link_host_pkg::ADDR_CTRL_TWO, 8'h01);
      rd_chk(link_host_pkg::ADDR_CTRL_TWO, 8'h01);
      rd_chk(VEC, 8'h00);
      print_verdict();
   end
endmodule // link_host_if_tb
